// ==== mfps_pkg.sv ====
/*
 * Package for the multifunction pin status selector.
 * Holds select codes, status bit positions, APB register map and reset values.
 * Assumes a 32-bit APB master and a 100 MHz core clock.
 */
package mfps_pkg;
    // APB register byte offsets
    localparam logic [7:0] MFPS_OFS_SELECT = 8'h00;
    localparam logic [7:0] MFPS_OFS_PIN = 8'h04;
    localparam logic [7:0] MFPS_OFS_IRQ_STATUS = 8'h08;
    localparam logic [7:0] MFPS_OFS_IRQ_MASK = 8'h0C;
    // Reset values
    localparam logic [7:0] MFPS_SELECT_RST = 8'h00;
    localparam logic [1:0] MFPS_MASK_RST = 2'h0;
    // Direction bit of the select value
    localparam int MFPS_DIR_BIT = 7;
    // Interrupt status bit positions
    localparam int MFPS_IRQ_HIST0 = 0;
    localparam int MFPS_IRQ_HIST1 = 1;
    // Lock status register bit positions
    localparam int MFPS_LK_PHASE = 1;
    localparam int MFPS_LK_FREQ = 2;
    localparam int MFPS_LK_ALOCK = 3;
    localparam int MFPS_LK_ACAL = 4;
    // Loop state register bit positions
    localparam int MFPS_ST_FREE = 0;
    localparam int MFPS_ST_HOLD = 1;
    localparam int MFPS_ST_SWITCH = 2;
    // History status register bit positions
    localparam int MFPS_HS_AVAIL = 0;
    localparam int MFPS_HS_CLAMP = 1;
    localparam int MFPS_HS_SLEW = 2;
    localparam int MFPS_HS_DEMAP = 3;
    // Event register bit position
    localparam int MFPS_EV_HIST = 4;
    // Reference status: loop active bits start here
    localparam int MFPS_REF_ACT_LSB = 4;
    // Output select codes
    localparam logic [7:0] MFPS_SEL_REF4_ACTIVE = 8'hB3;
    localparam logic [7:0] MFPS_SEL_L0_BASE = 8'hC0;
    localparam logic [7:0] MFPS_SEL_L1_BASE = 8'hD0;
    localparam logic [7:0] MFPS_SEL_L2_PHASE = 8'hE0;
    localparam logic [7:0] MFPS_SEL_L2_FREQ = 8'hE1;
    // Low-nibble offsets inside a loop group
    localparam logic [3:0] MFPS_SUB_PHASE = 4'h0;
    localparam logic [3:0] MFPS_SUB_FREQ = 4'h1;
    localparam logic [3:0] MFPS_SUB_ALOCK = 4'h2;
    localparam logic [3:0] MFPS_SUB_ACAL = 4'h3;
    localparam logic [3:0] MFPS_SUB_ACTIVE = 4'h4;
    localparam logic [3:0] MFPS_SUB_FREE = 4'h5;
    localparam logic [3:0] MFPS_SUB_HOLD = 4'h6;
    localparam logic [3:0] MFPS_SUB_SWITCH = 4'h7;
    localparam logic [3:0] MFPS_SUB_AVAIL = 4'h8;
    localparam logic [3:0] MFPS_SUB_HUPD = 4'h9;
    localparam logic [3:0] MFPS_SUB_CLAMP = 4'hA;
    localparam logic [3:0] MFPS_SUB_SLEW = 4'hB;
    localparam logic [3:0] MFPS_SUB_SYNC = 4'hC;
    localparam logic [3:0] MFPS_SUB_DEMAP = 4'hD;
endpackage

// ==== mfps_pin_select.sv ====
/*
 * Multifunction pin status selector with APB register access.
 * Assumes status inputs synchronous to i_core_clk and a standard APB master.
 */
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - Select bit seven set means status output.
// - 0xB3 gives reference four active, any loop.
// - 0xC0-C3 give loop zero lock bits.
// - 0xC4 gives loop zero active, ORed.
// - 0xC5-C7 give loop zero state bits.
// - 0xC8, CA, CB give loop zero history bits.
// - 0xC9 gives loop zero history event, unmasked.
// - 0xCC gives loop zero sync pulse.
// - 0xCD gives loop zero demapping clamp flag.
// - 0xD0-D3 give loop one lock bits.
// - 0xD4 gives loop one active, ORed.
// - 0xD5-D7 give loop one state bits.
// - 0xD8, DA, DB give loop one history bits.
// - 0xD9 gives loop one history event, unmasked.
// - 0xDC gives loop one sync pulse.
// - 0xDD gives loop one demapping clamp flag.
// - 0xE0-E1 give loop two lock bits.
module mfps_pin_select
    import mfps_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Reference status, one byte per reference
    input wire logic [7:0] i_ref_status_one,
    input wire logic [7:0] i_ref_status_two,
    input wire logic [7:0] i_ref_status_three,
    input wire logic [7:0] i_ref_status_four,
    // Loop zero status
    input wire logic [7:0] i_loop_zero_lock,
    input wire logic [7:0] i_loop_zero_state,
    input wire logic [7:0] i_loop_zero_hist,
    input wire logic [7:0] i_loop_zero_event,
    input wire logic i_loop_zero_sync,
    // Loop one status
    input wire logic [7:0] i_loop_one_lock,
    input wire logic [7:0] i_loop_one_state,
    input wire logic [7:0] i_loop_one_hist,
    input wire logic [7:0] i_loop_one_event,
    input wire logic i_loop_one_sync,
    // Loop two status
    input wire logic [7:0] i_loop_two_lock,
    // Pin and interrupt
    output logic o_pin_out,
    output logic o_pin_oe,
    output logic o_irq
);

    typedef enum logic [1:0] {
        MFPS_APB_IDLE = 2'b00,
        MFPS_APB_ACCESS = 2'b01
    } mfps_apb_e;

    logic [7:0] select;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    mfps_apb_e apb_state;
    logic [1:0] hist_prev;

    // Picks one loop's status by low nibble
    function automatic logic loop_pick(input logic [3:0] sub, input logic [7:0] lk, input logic [7:0] st,
                                       input logic [7:0] hs, input logic [7:0] ev, input logic act,
                                       input logic sync);
        logic r;
        r = 1'b0;
        case (sub)
            MFPS_SUB_PHASE: r = lk[MFPS_LK_PHASE];
            MFPS_SUB_FREQ: r = lk[MFPS_LK_FREQ];
            MFPS_SUB_ALOCK: r = lk[MFPS_LK_ALOCK];
            MFPS_SUB_ACAL: r = lk[MFPS_LK_ACAL];
            MFPS_SUB_ACTIVE: r = act;
            MFPS_SUB_FREE: r = st[MFPS_ST_FREE];
            MFPS_SUB_HOLD: r = st[MFPS_ST_HOLD];
            MFPS_SUB_SWITCH: r = st[MFPS_ST_SWITCH];
            MFPS_SUB_AVAIL: r = hs[MFPS_HS_AVAIL];
            MFPS_SUB_HUPD: r = ev[MFPS_EV_HIST];
            MFPS_SUB_CLAMP: r = hs[MFPS_HS_CLAMP];
            MFPS_SUB_SLEW: r = hs[MFPS_HS_SLEW];
            MFPS_SUB_SYNC: r = sync;
            MFPS_SUB_DEMAP: r = hs[MFPS_HS_DEMAP];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Loop active across the four reference status bytes
    wire logic [3:0] loop_active_vec = {i_ref_status_one[MFPS_REF_ACT_LSB + 3], i_ref_status_one[MFPS_REF_ACT_LSB + 2],
                                        i_ref_status_one[MFPS_REF_ACT_LSB + 1], i_ref_status_one[MFPS_REF_ACT_LSB]}
                                     | {i_ref_status_two[MFPS_REF_ACT_LSB + 3], i_ref_status_two[MFPS_REF_ACT_LSB + 2],
                                        i_ref_status_two[MFPS_REF_ACT_LSB + 1], i_ref_status_two[MFPS_REF_ACT_LSB]}
                                     | {i_ref_status_three[MFPS_REF_ACT_LSB + 3],
                                        i_ref_status_three[MFPS_REF_ACT_LSB + 2],
                                        i_ref_status_three[MFPS_REF_ACT_LSB + 1],
                                        i_ref_status_three[MFPS_REF_ACT_LSB]}
                                     | {i_ref_status_four[MFPS_REF_ACT_LSB + 3],
                                        i_ref_status_four[MFPS_REF_ACT_LSB + 2],
                                        i_ref_status_four[MFPS_REF_ACT_LSB + 1],
                                        i_ref_status_four[MFPS_REF_ACT_LSB]};
    wire logic loop_zero_active = loop_active_vec[0];
    wire logic loop_one_active = loop_active_vec[1];
    wire logic ref_four_active = |i_ref_status_four[MFPS_REF_ACT_LSB +: 4];

    // Selection
    wire logic is_output = select[MFPS_DIR_BIT];
    wire logic [3:0] sel_hi = select[7:4];
    wire logic [3:0] sel_lo = select[3:0];
    wire logic pick_zero = loop_pick(sel_lo, i_loop_zero_lock, i_loop_zero_state, i_loop_zero_hist,
                                     i_loop_zero_event, loop_zero_active, i_loop_zero_sync);
    wire logic pick_one = loop_pick(sel_lo, i_loop_one_lock, i_loop_one_state, i_loop_one_hist,
                                    i_loop_one_event, loop_one_active, i_loop_one_sync);
    wire logic is_zero_grp = sel_hi == MFPS_SEL_L0_BASE[7:4];
    wire logic is_one_grp = sel_hi == MFPS_SEL_L1_BASE[7:4];
    wire logic next_pin = !is_output ? 1'b0 :
                          (select == MFPS_SEL_REF4_ACTIVE) ? ref_four_active :
                          is_zero_grp ? pick_zero :
                          is_one_grp ? pick_one :
                          (select == MFPS_SEL_L2_PHASE) ? i_loop_two_lock[MFPS_LK_PHASE] :
                          (select == MFPS_SEL_L2_FREQ) ? i_loop_two_lock[MFPS_LK_FREQ] : 1'b0;

    // APB decode
    wire logic apb_setup = i_psel && !i_penable && apb_state == MFPS_APB_IDLE;
    wire logic apb_done = i_psel && i_penable && apb_state == MFPS_APB_ACCESS;
    wire logic hit_select = i_paddr == MFPS_OFS_SELECT;
    wire logic hit_pin = i_paddr == MFPS_OFS_PIN;
    wire logic hit_status = i_paddr == MFPS_OFS_IRQ_STATUS;
    wire logic hit_mask = i_paddr == MFPS_OFS_IRQ_MASK;
    wire logic hit_any = hit_select | hit_pin | hit_status | hit_mask;
    wire logic wr_select = apb_done && i_pwrite && hit_select;
    wire logic wr_mask = apb_done && i_pwrite && hit_mask;
    wire logic rd_status = apb_done && !i_pwrite && hit_status;
    wire logic [31:0] rd_mux = hit_select ? {24'h000000, select} :
                               hit_pin ? {30'h0, o_pin_oe, o_pin_out} :
                               hit_status ? {30'h0, irq_status} :
                               hit_mask ? {30'h0, irq_mask} : 32'h00000000;

    // History-updated rising edges as events, set wins over read clear
    wire logic [1:0] hist_now = {i_loop_one_event[MFPS_EV_HIST], i_loop_zero_event[MFPS_EV_HIST]};
    wire logic [1:0] hist_rise = hist_now & ~hist_prev;
    // Read clears only the bits it reported, so a late event is kept
    wire logic [1:0] next_irq_status = (irq_status & ~(rd_status ? o_prdata[1:0] : 2'h0)) | hist_rise;
    wire logic next_irq = |(next_irq_status & (wr_mask ? i_pwdata[1:0] : irq_mask));

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            apb_state <= MFPS_APB_IDLE;
            o_pready <= 1'b0;
        end else if (i_ce) begin
            apb_state <= apb_setup ? MFPS_APB_ACCESS : MFPS_APB_IDLE;
            o_pready <= apb_setup;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_prdata <= 32'h00000000;
            o_pslverr <= 1'b0;
        end else if (i_ce && apb_setup) begin
            o_prdata <= i_pwrite ? 32'h00000000 : rd_mux;
            o_pslverr <= !hit_any;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            select <= MFPS_SELECT_RST;
            irq_mask <= MFPS_MASK_RST;
        end else if (i_ce) begin
            if (wr_select) begin
                select <= i_pwdata[7:0];
            end
            if (wr_mask) begin
                irq_mask <= i_pwdata[1:0];
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            irq_status <= 2'h0;
            hist_prev <= 2'h0;
            o_irq <= 1'b0;
        end else if (i_ce) begin
            irq_status <= next_irq_status;
            hist_prev <= hist_now;
            o_irq <= next_irq;
        end
    end

    // Pin output register
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_pin_out <= 1'b0;
            o_pin_oe <= 1'b0;
        end else if (i_ce) begin
            o_pin_out <= next_pin;
            o_pin_oe <= is_output;
        end
    end

    // Assertions
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    input_zero_a: assert property (i_ce && !is_output |=> !o_pin_out && !o_pin_oe)
        else $error("Pin not released for input select");
    ref_four_a: assert property (i_ce && select == 8'hB3 |=> o_pin_out == $past(|i_ref_status_four[7:4]))
        else $error("Reference four active wrong");
    loop0_lock_a: assert property (i_ce && select == 8'hC2 |=> o_pin_out == $past(i_loop_zero_lock[3]))
        else $error("Loop zero lock wrong");
    loop0_act_a: assert property (i_ce && select == 8'hC4 |=> o_pin_out == $past(i_ref_status_one[4]
        | i_ref_status_two[4] | i_ref_status_three[4] | i_ref_status_four[4]))
        else $error("Loop zero active wrong");
    loop0_hupd_a: assert property (i_ce && select == 8'hC9 |=> o_pin_out == $past(i_loop_zero_event[4]))
        else $error("Loop zero history event wrong");
    loop0_demap_a: assert property (i_ce && select == 8'hCD |=> o_pin_out == $past(i_loop_zero_hist[3]))
        else $error("Demapping clamp wrong");
    loop1_act_a: assert property (i_ce && select == 8'hD4 |=> o_pin_out == $past(i_ref_status_one[5]
        | i_ref_status_two[5] | i_ref_status_three[5] | i_ref_status_four[5]))
        else $error("Loop one active wrong");
    loop1_sync_a: assert property (i_ce && select == 8'hDC |=> o_pin_out == $past(i_loop_one_sync))
        else $error("Loop one sync wrong");
    loop2_freq_a: assert property (i_ce && select == 8'hE1 |=> o_pin_out == $past(i_loop_two_lock[2]))
        else $error("Loop two frequency lock wrong");
    unassigned_a: assert property (i_ce && select == 8'hCE |=> !o_pin_out)
        else $error("Unassigned code not zero");
    apb_ready_a: assert property (i_psel && !i_penable && !o_pready && i_ce |=> o_pready ##1 !o_pready)
        else $error("APB ready timing wrong");

    // Loop zero codes
    loop0_phase_a: assert property (
        i_ce && select == 8'hC0
        |=> o_pin_out == $past(i_loop_zero_lock[1]))
        else $error("Loop zero phase lock wrong");
    loop0_freq_a: assert property (
        i_ce && select == 8'hC1
        |=> o_pin_out == $past(i_loop_zero_lock[2]))
        else $error("Loop zero frequency lock wrong");
    loop0_cal_a: assert property (
        i_ce && select == 8'hC3
        |=> o_pin_out == $past(i_loop_zero_lock[4]))
        else $error("Loop zero calibration wrong");
    loop0_free_a: assert property (
        i_ce && select == 8'hC5
        |=> o_pin_out == $past(i_loop_zero_state[0]))
        else $error("Loop zero free run wrong");
    loop0_hold_a: assert property (
        i_ce && select == 8'hC6
        |=> o_pin_out == $past(i_loop_zero_state[1]))
        else $error("Loop zero holdover wrong");
    loop0_switch_a: assert property (
        i_ce && select == 8'hC7
        |=> o_pin_out == $past(i_loop_zero_state[2]))
        else $error("Loop zero switching wrong");
    loop0_avail_a: assert property (
        i_ce && select == 8'hC8
        |=> o_pin_out == $past(i_loop_zero_hist[0]))
        else $error("Loop zero history available wrong");
    loop0_clamp_a: assert property (
        i_ce && select == 8'hCA
        |=> o_pin_out == $past(i_loop_zero_hist[1]))
        else $error("Loop zero clamp wrong");
    loop0_slew_a: assert property (
        i_ce && select == 8'hCB
        |=> o_pin_out == $past(i_loop_zero_hist[2]))
        else $error("Loop zero slew limit wrong");
    loop0_sync_a: assert property (
        i_ce && select == 8'hCC
        |=> o_pin_out == $past(i_loop_zero_sync))
        else $error("Loop zero sync wrong");

    // Loop one codes
    loop1_phase_a: assert property (
        i_ce && select == 8'hD0
        |=> o_pin_out == $past(i_loop_one_lock[1]))
        else $error("Loop one phase lock wrong");
    loop1_freq_a: assert property (
        i_ce && select == 8'hD1
        |=> o_pin_out == $past(i_loop_one_lock[2]))
        else $error("Loop one frequency lock wrong");
    loop1_alock_a: assert property (
        i_ce && select == 8'hD2
        |=> o_pin_out == $past(i_loop_one_lock[3]))
        else $error("Loop one analog lock wrong");
    loop1_cal_a: assert property (
        i_ce && select == 8'hD3
        |=> o_pin_out == $past(i_loop_one_lock[4]))
        else $error("Loop one calibration wrong");
    loop1_free_a: assert property (
        i_ce && select == 8'hD5
        |=> o_pin_out == $past(i_loop_one_state[0]))
        else $error("Loop one free run wrong");
    loop1_hold_a: assert property (
        i_ce && select == 8'hD6
        |=> o_pin_out == $past(i_loop_one_state[1]))
        else $error("Loop one holdover wrong");
    loop1_switch_a: assert property (
        i_ce && select == 8'hD7
        |=> o_pin_out == $past(i_loop_one_state[2]))
        else $error("Loop one switchover wrong");
    loop1_avail_a: assert property (
        i_ce && select == 8'hD8
        |=> o_pin_out == $past(i_loop_one_hist[0]))
        else $error("Loop one history available wrong");
    loop1_hupd_a: assert property (
        i_ce && select == 8'hD9
        |=> o_pin_out == $past(i_loop_one_event[4]))
        else $error("Loop one history event wrong");
    loop1_clamp_a: assert property (
        i_ce && select == 8'hDA
        |=> o_pin_out == $past(i_loop_one_hist[1]))
        else $error("Loop one clamp wrong");
    loop1_slew_a: assert property (
        i_ce && select == 8'hDB
        |=> o_pin_out == $past(i_loop_one_hist[2]))
        else $error("Loop one slew limit wrong");
    loop1_demap_a: assert property (
        i_ce && select == 8'hDD
        |=> o_pin_out == $past(i_loop_one_hist[3]))
        else $error("Loop one demapping clamp wrong");

    // Loop two, unassigned, direction
    loop2_phase_a: assert property (
        i_ce && select == 8'hE0
        |=> o_pin_out == $past(i_loop_two_lock[1]))
        else $error("Loop two phase lock wrong");
    unassigned_hi_a: assert property (
        i_ce && select == 8'hE2
        |=> !o_pin_out)
        else $error("Unassigned high code not zero");
    pin_dir_a: assert property (
        i_ce
        |=> o_pin_oe == $past(select[7]))
        else $error("Pin direction wrong");

    // Interrupt, bus error, clock enable
    irq_event_a: assert property (
        i_ce && hist_rise[0]
        |=> irq_status[0])
        else $error("History event not captured");
    irq_clear_a: assert property (
        i_ce && rd_status && hist_rise == 2'h0
        |=> (irq_status & $past(o_prdata[1:0])) == 2'h0)
        else $error("Status read did not clear");
    apb_err_a: assert property (
        i_ce && apb_setup && !hit_any
        |=> o_pslverr && o_pready)
        else $error("Unmapped access not flagged");
    ce_hold_a: assert property (
        !i_ce
        |=> $stable(o_pin_out) && $stable(o_pin_oe) && $stable(select))
        else $error("State moved with enable low");

    loop0_sel_c: cover property (select == 8'hC0 && o_pin_out);
    loop1_sel_c: cover property (select == 8'hD9 && o_pin_out);
    irq_fire_c: cover property (o_irq ##1 !o_irq);
    pin_release_c: cover property (o_pin_oe ##1 !o_pin_oe);
    ce_freeze_c: cover property (!i_ce ##1 !i_ce);
endmodule

// ==== mfps_board_obs.sv ====
/*
 * Board-side observer of the multifunction pin.
 * Assumes the pin is sampled on the core clock and has a pull-up on the board.
 */
`timescale 1ns/1ps
module mfps_board_obs (
    // Clock
    input wire logic i_core_clk,
    // Pin
    input wire logic i_pin,
    input wire logic i_pin_oe,
    // Sampled level
    output logic o_seen
);
    // Undriven pin reads the pull-up level
    always_ff @(posedge i_core_clk) begin
        o_seen <= i_pin_oe ? i_pin : 1'b1;
    end
endmodule

// ==== test_multifunction_pin_status_select.sv ====
/*
 * Testbench for the multifunction pin status selector.
 * Assumes mfps_pkg and the board observer are compiled first.
 */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module test_multifunction_pin_status_select;
    import mfps_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic ce = 1'b1;
    logic pready, pslverr, pin, oe, irq, seen, er, ex, orc, pv;
    logic [31:0] rd;
    logic [7:0] st [14];
    int err_total = 0;
    int num_checks = 0;
    // Select code, source index, source bit
    logic [15:0] tbl [33] = '{16'hB337, 16'hC041, 16'hC142, 16'hC243, 16'hC344, 16'hC404, 16'hC550,
        16'hC651, 16'hC752, 16'hC860, 16'hCA61, 16'hCB62, 16'hC974, 16'hCCD0, 16'hCD63, 16'hD081,
        16'hD182, 16'hD283, 16'hD384, 16'hD425, 16'hD590, 16'hD691, 16'hD792, 16'hD8A0, 16'hDAA1,
        16'hDBA2, 16'hD9B4, 16'hDCD1, 16'hDDA3, 16'hE0C1, 16'hE1C2, 16'h0000, 16'h0000};
    logic [7:0] bad [5] = '{8'hCE, 8'hDE, 8'hE2, 8'hFF, 8'h40};

    always #5 i_core_clk = ~i_core_clk;

    mfps_pin_select uut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ce(ce),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_ref_status_one(st[0]), .i_ref_status_two(st[1]), .i_ref_status_three(st[2]),
        .i_ref_status_four(st[3]), .i_loop_zero_lock(st[4]), .i_loop_zero_state(st[5]),
        .i_loop_zero_hist(st[6]), .i_loop_zero_event(st[7]), .i_loop_zero_sync(st[13][0]),
        .i_loop_one_lock(st[8]), .i_loop_one_state(st[9]), .i_loop_one_hist(st[10]),
        .i_loop_one_event(st[11]), .i_loop_one_sync(st[13][1]), .i_loop_two_lock(st[12]),
        .o_pin_out(pin), .o_pin_oe(oe), .o_irq(irq));

    mfps_board_obs obs (.i_core_clk(i_core_clk), .i_pin(pin), .i_pin_oe(oe), .o_seen(seen));

    task automatic end_sim();
        $display("Checks %0d, errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One APB transfer, result left in rd and er
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_core_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            err_total++;
            end_sim();
        end
    endtask

    // Drive every status bit to ~lvl except one bit at lvl
    task automatic drive(input int idx, input int bt, input logic lvl);
        @(posedge i_core_clk);
        for (int i = 0; i < 14; i++) begin
            for (int b = 0; b < 8; b++) begin
                st[i][b] <= (i == idx && b == bt) ? lvl : ~lvl;
            end
        end
    endtask

    initial begin
        foreach (st[i]) st[i] = 8'h00;
        repeat (12) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        apb(1'b0, MFPS_OFS_SELECT, 32'h0);
        `CHK("select reset", 32'h0, rd)
        apb(1'b0, MFPS_OFS_IRQ_MASK, 32'h0);
        `CHK("mask reset", 32'h0, rd)
        `CHK("oe reset", 1'b0, oe)
        for (int k = 0; k < 31; k++) begin
            apb(1'b1, MFPS_OFS_SELECT, {24'h0, tbl[k][15:8]});
            orc = tbl[k][15:8] inside {8'hB3, 8'hC4, 8'hD4};
            for (int v = 0; v < 3; v++) begin
                pv = ex;
                ex = (v == 0) || (v == 1 && orc);
                drive((v == 2) ? 15 : int'(tbl[k][7:4]), int'(tbl[k][3:0]), v != 1);
                #1;
                if (v > 0) `CHK("pin latency", pv, pin)
                @(posedge i_core_clk) #1;
                `CHK("pin", ex, pin)
                @(posedge i_core_clk) #1;
                `CHK("board sample", ex, seen)
            end
        end
        foreach (bad[k]) begin
            apb(1'b1, MFPS_OFS_SELECT, {24'h0, bad[k]});
            drive(15, 0, 1'b0);
            repeat (3) @(posedge i_core_clk);
            #1;
            `CHK("unassigned pin", 1'b0, pin)
            `CHK("pin direction", bad[k][7], oe)
            `CHK("board level", !bad[k][7], seen)
            apb(1'b0, MFPS_OFS_PIN, 32'h0);
            `CHK("pin readback", {30'h0, bad[k][7], 1'b0}, rd)
        end
        drive(15, 0, 1'b1);
        apb(1'b0, MFPS_OFS_IRQ_STATUS, 32'h0);
        apb(1'b0, MFPS_OFS_IRQ_STATUS, 32'h0);
        `CHK("status cleared", 32'h0, rd)
        drive(7, 4, 1'b1);
        repeat (3) @(posedge i_core_clk);
        #1;
        `CHK("masked irq", 1'b0, irq)
        apb(1'b0, MFPS_OFS_IRQ_STATUS, 32'h0);
        `CHK("status event", 32'h1, rd)
        apb(1'b1, MFPS_OFS_IRQ_MASK, 32'h3);
        apb(1'b0, MFPS_OFS_IRQ_MASK, 32'h0);
        `CHK("mask readback", 32'h3, rd)
        drive(11, 4, 1'b1);
        repeat (3) @(posedge i_core_clk);
        #1;
        `CHK("irq raised", 1'b1, irq)
        apb(1'b0, MFPS_OFS_IRQ_STATUS, 32'h0);
        `CHK("status event two", 32'h2, rd)
        repeat (2) @(posedge i_core_clk);
        #1;
        `CHK("irq cleared", 1'b0, irq)
        apb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped error", 1'b1, er)
        `CHK("unmapped data", 32'h0, rd)
        // Clock enable low freezes the pin
        apb(1'b1, MFPS_OFS_SELECT, {24'h0, MFPS_SEL_L0_BASE});
        drive(4, 1, 1'b1);
        repeat (3) @(posedge i_core_clk);
        ce <= 1'b0;
        drive(15, 0, 1'b1);
        repeat (3) @(posedge i_core_clk);
        #1;
        `CHK("frozen pin", 1'b1, pin)
        @(posedge i_core_clk);
        ce <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        #1;
        `CHK("resumed pin", 1'b0, pin)
        end_sim();
    end
endmodule
